// ===== design/aorsl_pkg.sv
// Constants for the alarm routing and set point limiter block
package aorsl_pkg;
    // Register byte offsets
    localparam logic [5:0] OFS_AUX_SEL = 6'h00;
    localparam logic [5:0] OFS_ALM_TYPE = 6'h04;
    localparam logic [5:0] OFS_ALM_POL = 6'h08;
    localparam logic [5:0] OFS_CTRL = 6'h0c;
    localparam logic [5:0] OFS_IN_TYPE = 6'h10;
    localparam logic [5:0] OFS_SCALE_HI = 6'h14;
    localparam logic [5:0] OFS_SCALE_LO = 6'h18;
    localparam logic [5:0] OFS_DECIMAL = 6'h1c;
    localparam logic [5:0] OFS_SP_CEIL = 6'h20;
    localparam logic [5:0] OFS_SP_FLOOR = 6'h24;
    localparam logic [5:0] OFS_SET_POINT = 6'h28;
    localparam logic [5:0] OFS_WORK_SP = 6'h2c;
    localparam logic [5:0] OFS_STATUS = 6'h30;
    localparam logic [5:0] OFS_CLASS = 6'h34;
    // Field positions
    localparam int POS_AUX2 = 8;
    localparam int POS_TYPE2 = 8;
    localparam int POS_TYPE3 = 16;
    localparam int POS_SENSE = 0;
    localparam int POS_RSP_EN = 1;
    localparam int POS_SECURITY = 4;
    // Auxiliary output source codes
    localparam logic [3:0] SRC_ALARM1 = 4'h0;
    localparam logic [3:0] SRC_ALARM2 = 4'h1;
    localparam logic [3:0] SRC_ALARM3 = 4'h2;
    localparam logic [3:0] SRC_RSP_ERR = 4'h7;
    localparam logic [3:0] SRC_HEAT = 4'h8;
    localparam logic [3:0] SRC_COOL = 4'h9;
    // Alarm type codes
    localparam logic [3:0] TYPE_MIN = 4'h1;
    localparam logic [3:0] TYPE_ABS_FIRST = 4'h8;
    localparam logic [3:0] TYPE_MAX = 4'hb;
    // Input type codes
    localparam logic [4:0] ITYPE_LAST_TEMP = 5'h10;
    localparam logic [4:0] ITYPE_MAX = 5'h15;
    // Values after reset, and the highest security level that leaves the limits open
    localparam logic [3:0] RST_AUX1 = SRC_ALARM2;
    localparam logic [3:0] RST_AUX2 = SRC_ALARM3;
    localparam logic [3:0] RST_TYPE = 4'h2;
    localparam logic [4:0] RST_IN_TYPE = 5'h02;
    localparam logic [15:0] RST_SP_CEIL = 16'h0514;
    localparam logic [15:0] RST_SP_FLOOR = 16'hff38;
    localparam logic [15:0] RST_SCALE_HI = 16'h0064;
    localparam logic [15:0] RST_SCALE_LO = 16'h0000;
    localparam logic [2:0] RST_SECURITY = 3'h1;
    localparam logic [2:0] SEC_OPEN_MAX = 3'h1;
endpackage

// ===== design/aorsl_top.sv
// Alarm output routing, alarm type decode and set point limiter
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module aorsl_top
    import aorsl_pkg::*;
#(
    parameter int VW = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Avalon-MM register slave
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Function states from the alarm and diagnostic logic
    input wire logic [2:0] alarm_state,
    input wire logic heater_burnout_alarm,
    input wire logic loop_break_alarm,
    input wire logic input_error,
    input wire logic converter_error,
    input wire logic rsp_error,
    // Measured process value
    input wire logic [VW-1:0] process_value,
    // Relays and lamps
    output logic aux_out_one,
    output logic aux_out_two,
    output logic aux_lamp_one,
    output logic aux_lamp_two,
    // Signed error term driving the manipulated variable
    output logic [VW-1:0] control_error
);
    // Only the 16-bit value path is built
    if (VW != 16) begin : g_vw_check
        $error("aorsl_top supports VW of 16 only");
    end

    typedef logic signed [15:0] aorsl_val_t;

    // Sensor range: {top, bottom, decimal point} per temperature code
    function automatic logic [33:0] sensor_range(input logic [4:0] code);
        case (code)
            5'h00, 5'h01: sensor_range = {16'h1964, 16'hf831, 2'h1};
            5'h02, 5'h0b: sensor_range = {16'h0514, 16'hff38, 2'h0};
            5'h03: sensor_range = {16'h1388, 16'h0000, 2'h1};
            5'h04, 5'h08: sensor_range = {16'h0352, 16'hff9c, 2'h0};
            5'h05, 5'h09: sensor_range = {16'h0fa0, 16'h0000, 2'h1};
            5'h06, 5'h0a: sensor_range = {16'h0fa0, 16'hf831, 2'h1};
            5'h07: sensor_range = {16'h0258, 16'h0000, 2'h0};
            5'h0c, 5'h0d: sensor_range = {16'h06a4, 16'h0000, 2'h0};
            5'h0e: sensor_range = {16'h0708, 16'h0064, 2'h0};
            5'h0f: sensor_range = {16'h08fc, 16'h0000, 2'h0};
            default: sensor_range = {16'h0514, 16'h0000, 2'h0};
        endcase
    endfunction

    // Alarm type class: {absolute, standby, range, upper, lower}
    function automatic logic [4:0] type_class(input logic [3:0] t);
        case (t)
            4'h1: type_class = 5'b00011;
            4'h2: type_class = 5'b00010;
            4'h3: type_class = 5'b00001;
            4'h4: type_class = 5'b00100;
            4'h5: type_class = 5'b01011;
            4'h6: type_class = 5'b01010;
            4'h7: type_class = 5'b01001;
            4'h8: type_class = 5'b10010;
            4'h9: type_class = 5'b10001;
            4'ha: type_class = 5'b11010;
            4'hb: type_class = 5'b11001;
            default: type_class = 5'b00000;
        endcase
    endfunction

    // Configuration state
    logic [3:0] aux_sel1;
    logic [3:0] aux_sel2;
    logic [3:0] alm_type [3];
    logic [2:0] open_in_alarm;
    logic direct_sense;
    logic rsp_enable;
    logic [2:0] security;
    logic [4:0] input_type;
    aorsl_val_t scale_hi;
    aorsl_val_t scale_lo;
    logic [1:0] scale_dp;
    aorsl_val_t set_point_ceiling;
    aorsl_val_t set_point_floor;
    aorsl_val_t set_point;
    aorsl_val_t working_sp;
    // Synchronisers for pin inputs
    logic [7:0] fn_meta;
    logic [7:0] fn_sync;
    logic [15:0] pv_meta;
    aorsl_val_t pv_sync;

    // Bus decode
    wire wr = avs_write & ~avs_waitrequest & (avs_byteenable == 4'hf);
    wire [31:0] wd = avs_writedata;
    wire wr_sel = wr && avs_address == OFS_AUX_SEL;
    wire wr_type = wr && avs_address == OFS_ALM_TYPE;
    wire wr_pol = wr && avs_address == OFS_ALM_POL;
    wire wr_ctrl = wr && avs_address == OFS_CTRL;
    wire wr_itype = wr && avs_address == OFS_IN_TYPE;
    wire wr_shi = wr && avs_address == OFS_SCALE_HI;
    wire wr_slo = wr && avs_address == OFS_SCALE_LO;
    wire wr_dp = wr && avs_address == OFS_DECIMAL;
    wire wr_ceil = wr && avs_address == OFS_SP_CEIL;
    wire wr_floor = wr && avs_address == OFS_SP_FLOOR;
    wire wr_sp = wr && avs_address == OFS_SET_POINT;

    // Source selection checks
    wire [3:0] new_sel1 = wd[3:0];
    wire [3:0] new_sel2 = wd[POS_AUX2+3:POS_AUX2];
    wire sel_ok1 = new_sel1 < SRC_HEAT &&
        (new_sel1 != SRC_RSP_ERR || rsp_enable);
    wire sel_ok2 = new_sel2 < SRC_HEAT &&
        (new_sel2 != SRC_RSP_ERR || rsp_enable);

    // Which alarms are routed to an output
    wire [2:0] routed;
    genvar g;
    for (g = 0; g < 3; g++) begin : g_route
        assign routed[g] = aux_sel1 == 4'(g) || aux_sel2 == 4'(g);
    end

    // Alarm type write data and acceptance
    wire [3:0] new_type [3];
    assign new_type[0] = wd[3:0];
    assign new_type[1] = wd[POS_TYPE2+3:POS_TYPE2];
    assign new_type[2] = wd[POS_TYPE3+3:POS_TYPE3];
    wire [2:0] type_ok;
    for (g = 0; g < 3; g++) begin : g_tok
        assign type_ok[g] = routed[g] && new_type[g] >= TYPE_MIN &&
            new_type[g] <= TYPE_MAX;
    end

    // Range and decimal point of the selected input
    wire is_temp = input_type <= ITYPE_LAST_TEMP;
    wire [33:0] srange = sensor_range(input_type);
    wire aorsl_val_t range_top = is_temp ? srange[33:18] : scale_hi;
    wire aorsl_val_t range_bot = is_temp ? srange[17:2] : scale_lo;
    wire [1:0] limit_dp = is_temp ? srange[1:0] : scale_dp;
    wire [4:0] new_itype = wd[4:0];
    wire [33:0] nrange = sensor_range(new_itype);
    wire itype_chg = wr_itype && new_itype <= ITYPE_MAX &&
        new_itype != input_type;
    wire itype_temp = new_itype <= ITYPE_LAST_TEMP;

    // Expansion-mode gate and limit acceptance
    wire exp_open = security <= SEC_OPEN_MAX;
    wire aorsl_val_t wv = aorsl_val_t'(wd[15:0]);
    wire ceil_ok = exp_open && wv > set_point_floor &&
        wv <= range_top;
    wire floor_ok = exp_open && wv >= range_bot &&
        wv < set_point_ceiling;

    // Clamped working set point
    wire aorsl_val_t next_working_sp =
        set_point > set_point_ceiling ? set_point_ceiling :
        set_point < set_point_floor ? set_point_floor : set_point;

    // Routed function states and output polarity
    wire [3:0] s1 = aux_sel1;
    wire [3:0] s2 = aux_sel2;
    wire act1 = fn_sync[s1[2:0]] && (s1 != SRC_RSP_ERR || rsp_enable);
    wire act2 = fn_sync[s2[2:0]] && (s2 != SRC_RSP_ERR || rsp_enable);
    wire inv1 = s1 <= SRC_ALARM3 && open_in_alarm[s1[1:0]];
    wire inv2 = s2 <= SRC_ALARM3 && open_in_alarm[s2[1:0]];

    // Control error sense
    wire aorsl_val_t next_control_error = direct_sense ?
        aorsl_val_t'(pv_sync - working_sp) :
        aorsl_val_t'(working_sp - pv_sync);

    // Read data selection
    wire [4:0] cls [3];
    for (g = 0; g < 3; g++) begin : g_cls
        assign cls[g] = routed[g] ? type_class(alm_type[g]) : 5'h00;
    end
    wire [3:0] rd_type [3];
    for (g = 0; g < 3; g++) begin : g_rt
        assign rd_type[g] = routed[g] ? alm_type[g] : 4'h0;
    end
    logic [31:0] next_readdata;
    always_comb begin
        case (avs_address)
            OFS_AUX_SEL: next_readdata = {20'h0, aux_sel2, 4'h0, aux_sel1};
            OFS_ALM_TYPE: next_readdata = {12'h0, rd_type[2], 4'h0,
                rd_type[1], 4'h0, rd_type[0]};
            OFS_ALM_POL: next_readdata = {29'h0, open_in_alarm & routed};
            OFS_CTRL: next_readdata = {25'h0, security, 2'h0,
                rsp_enable, direct_sense};
            OFS_IN_TYPE: next_readdata = {27'h0, input_type};
            OFS_SCALE_HI: next_readdata = {16'h0, scale_hi};
            OFS_SCALE_LO: next_readdata = {16'h0, scale_lo};
            OFS_DECIMAL: next_readdata = {30'h0, scale_dp};
            OFS_SP_CEIL: next_readdata =
                exp_open ? {16'h0, set_point_ceiling} : 32'h0;
            OFS_SP_FLOOR: next_readdata =
                exp_open ? {16'h0, set_point_floor} : 32'h0;
            OFS_SET_POINT: next_readdata = {16'h0, set_point};
            OFS_WORK_SP: next_readdata = {16'h0, working_sp};
            OFS_STATUS: next_readdata = {14'h0, limit_dp, fn_sync,
                4'h0, aux_lamp_two, aux_lamp_one, aux_out_two, aux_out_one};
            OFS_CLASS: next_readdata = {17'h0, cls[2], cls[1], cls[0]};
            default: next_readdata = 32'h0;
        endcase
    end

    // Bus handshake: one wait cycle; read data loads at the edge that drops waitrequest, a write lands one edge later
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    // Pin synchronisers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fn_meta <= 8'h0;
            fn_sync <= 8'h0;
            pv_meta <= 16'h0;
            pv_sync <= 16'sh0;
        end else begin
            fn_meta <= {rsp_error, converter_error, input_error,
                loop_break_alarm, heater_burnout_alarm, alarm_state};
            fn_sync <= fn_meta;
            pv_meta <= process_value;
            pv_sync <= pv_meta;
        end
    end

    // Routing and alarm configuration
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aux_sel1 <= RST_AUX1;
            aux_sel2 <= RST_AUX2;
            alm_type <= '{RST_TYPE, RST_TYPE, RST_TYPE};
            open_in_alarm <= 3'h0;
            direct_sense <= 1'b0;
            rsp_enable <= 1'b0;
            security <= RST_SECURITY;
        end else begin
            if (wr_sel && sel_ok1) begin
                aux_sel1 <= new_sel1;
            end
            if (wr_sel && sel_ok2) begin
                aux_sel2 <= new_sel2;
            end
            for (int i = 0; i < 3; i++) begin
                if (wr_type && type_ok[i]) begin
                    alm_type[i] <= new_type[i];
                end
                if (wr_pol && routed[i]) begin
                    open_in_alarm[i] <= wd[i];
                end
            end
            if (wr_ctrl) begin
                direct_sense <= wd[POS_SENSE];
                rsp_enable <= wd[POS_RSP_EN];
                security <= wd[POS_SECURITY+2:POS_SECURITY];
            end
        end
    end

    // Input scaling and set point limits
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            input_type <= RST_IN_TYPE;
            scale_hi <= RST_SCALE_HI;
            scale_lo <= RST_SCALE_LO;
            scale_dp <= 2'h0;
            set_point_ceiling <= RST_SP_CEIL;
            set_point_floor <= RST_SP_FLOOR;
            set_point <= 16'sh0;
            working_sp <= 16'sh0;
        end else begin
            if (wr_itype && new_itype <= ITYPE_MAX) begin
                input_type <= new_itype;
            end
            if (wr_shi && wv > scale_lo) begin
                scale_hi <= wv;
            end
            if (wr_slo && wv < scale_hi) begin
                scale_lo <= wv;
            end
            if (wr_dp) begin
                scale_dp <= wd[1:0];
            end
            if (itype_chg) begin
                set_point_ceiling <= itype_temp ?
                    aorsl_val_t'(nrange[33:18]) : scale_hi;
                set_point_floor <= itype_temp ?
                    aorsl_val_t'(nrange[17:2]) : scale_lo;
            end else begin
                if (wr_ceil && ceil_ok) begin
                    set_point_ceiling <= wv;
                end
                if (wr_floor && floor_ok) begin
                    set_point_floor <= wv;
                end
            end
            if (wr_sp) begin
                set_point <= wv;
            end
            working_sp <= next_working_sp;
        end
    end

    // Physical outputs and lamps
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aux_out_one <= 1'b0;
            aux_out_two <= 1'b0;
            aux_lamp_one <= 1'b0;
            aux_lamp_two <= 1'b0;
            control_error <= '0;
        end else begin
            aux_out_one <= act1 ^ inv1;
            aux_out_two <= act2 ^ inv2;
            aux_lamp_one <= act1;
            aux_lamp_two <= act2;
            control_error <= next_control_error;
        end
    end

    // Checks
    property p_sel_legal;
        @(posedge clk_sys) disable iff (!arst_n)
        aux_sel1 < SRC_HEAT && aux_sel2 < SRC_HEAT;
    endproperty
    a_sel_legal: assert property (p_sel_legal)
        else $error("Auxiliary source holds a control output");
    property p_rsp_gate;
        @(posedge clk_sys) disable iff (!arst_n)
        wr_sel && new_sel1 == SRC_RSP_ERR && !rsp_enable
        |=> aux_sel1 == $past(aux_sel1);
    endproperty
    a_rsp_gate: assert property (p_rsp_gate)
        else $error("Remote error source taken while disabled");
    property p_lamp;
        @(posedge clk_sys) disable iff (!arst_n)
        ##1 aux_lamp_one == $past(act1);
    endproperty
    a_lamp: assert property (p_lamp)
        else $error("Lamp one does not follow its function");
    property p_polarity;
        @(posedge clk_sys) disable iff (!arst_n)
        ##1 aux_out_two == ($past(act2) ^ $past(inv2));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("Output two polarity wrong");
    property p_type_range;
        @(posedge clk_sys) disable iff (!arst_n)
        alm_type[0] >= TYPE_MIN && alm_type[0] <= TYPE_MAX;
    endproperty
    a_type_range: assert property (p_type_range)
        else $error("Alarm one type out of range");
    property p_clamp;
        @(posedge clk_sys) disable iff (!arst_n)
        ##2 $stable(set_point) && $stable(set_point_ceiling) &&
        $stable(set_point_floor) |-> working_sp <= set_point_ceiling &&
        (working_sp >= set_point_floor ||
        set_point_floor > set_point_ceiling);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("Working set point outside limits");
    property p_reload;
        @(posedge clk_sys) disable iff (!arst_n)
        itype_chg && !itype_temp |=>
        set_point_ceiling == $past(scale_hi) &&
        set_point_floor == $past(scale_lo);
    endproperty
    a_reload: assert property (p_reload)
        else $error("Analog change did not reload limits");
    property p_lock;
        @(posedge clk_sys) disable iff (!arst_n)
        wr_ceil && !exp_open && !itype_chg |=> $stable(set_point_ceiling);
    endproperty
    a_lock: assert property (p_lock)
        else $error("Ceiling written while locked");
    property p_wait;
        @(posedge clk_sys) disable iff (!arst_n)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait)
        else $error("Bus answer late");
    c_reload: cover property (@(posedge clk_sys) itype_chg && itype_temp);
    c_open: cover property (@(posedge clk_sys) inv1 && act1);
    c_clamp: cover property (@(posedge clk_sys)
        set_point > set_point_ceiling);
endmodule

// ===== test/aorsl_panel_model.sv
// Relay contact and lamp model at the auxiliary outputs
`timescale 1ns/1ps
module aorsl_panel_model (
    // Drive from the block
    input wire logic aux_out_one,
    input wire logic aux_out_two,
    input wire logic aux_lamp_one,
    input wire logic aux_lamp_two,
    // States seen by the plant and the operator
    output logic contact_one,
    output logic contact_two,
    output logic lit_one,
    output logic lit_two
);
    // Contacts close with the coil, lamps glow with their drive
    assign contact_one = aux_out_one;
    assign contact_two = aux_out_two;
    assign lit_one = aux_lamp_one;
    assign lit_two = aux_lamp_two;
endmodule

// ===== test/tb.sv
// Self-checking bench for the alarm routing and set point limiter
`timescale 1ns/1ps
module tb;
    import aorsl_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest;
    logic [7:0] fn = 8'h00;
    logic [15:0] process_value = 16'h0;
    logic [15:0] control_error;
    logic aux_out_one, aux_out_two, aux_lamp_one, aux_lamp_two;
    logic c1, c2, l1, l2;
    int failures = 0;
    int n_tests = 0;
    int seed = 32'h2044304c;
    int ceil = 1300;
    int flr = -200;
    int i, sp, pv, ws;

    // Free-running system clock
    always #50 clk_sys = ~clk_sys;

    aorsl_top aorsl_top_inst (.clk_sys(clk_sys), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .alarm_state(fn[2:0]),
        .heater_burnout_alarm(fn[3]), .loop_break_alarm(fn[4]),
        .input_error(fn[5]), .converter_error(fn[6]), .rsp_error(fn[7]),
        .process_value(process_value), .aux_out_one(aux_out_one),
        .aux_out_two(aux_out_two), .aux_lamp_one(aux_lamp_one),
        .aux_lamp_two(aux_lamp_two), .control_error(control_error));

    aorsl_panel_model aorsl_panel_model_inst (.aux_out_one(aux_out_one),
        .aux_out_two(aux_out_two), .aux_lamp_one(aux_lamp_one),
        .aux_lamp_two(aux_lamp_two), .contact_one(c1), .contact_two(c2),
        .lit_one(l1), .lit_two(l2));

    // Compare and count
    task check(input string nm, input logic [31:0] seen, e);
        n_tests++;
        if (seen !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, seen);
        end
    endtask

    // One Avalon access, held until waitrequest is sampled low
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        // Only the watchdog ends a wait that never answers
        do begin
            @(posedge clk_sys);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Read a word and compare the masked bits
    task rd(input logic [5:0] a, input string nm, input logic [31:0] e, m);
        bus(1'b0, a, 32'h0);
        check(nm, q & m, e);
    endtask

    // Lets pin changes pass the synchronisers and output registers
    task settle;
        repeat (6) @(posedge clk_sys);
    endtask

    // Class bits {abs, standby, range, upper, lower} of a type code
    function automatic logic [4:0] cls(input int t);
        logic ab, sb, rg, up, lo;
        ab = t >= 8;
        sb = (t >= 5 && t <= 7) || t >= 10;
        rg = t == 4;
        up = t inside {1, 2, 5, 6, 8, 10};
        lo = t inside {1, 3, 5, 7, 9, 11};
        return {ab, sb, rg, up, lo};
    endfunction

    task final_report;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #2000000;
        failures++;
        final_report;
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(OFS_AUX_SEL, "aux_sel", 32'h0201, '1);
        rd(OFS_ALM_TYPE, "types", 32'h020200, '1);
        rd(OFS_SP_CEIL, "ceil", 1300, 32'hffff);
        rd(OFS_SP_FLOOR, "floor", 16'hff38, 32'hffff);
        rd(6'h3c, "unmapped", 0, '1);
        bus(1'b1, OFS_AUX_SEL, 32'h0908);
        rd(OFS_AUX_SEL, "heat_cool", 32'h0201, '1);
        bus(1'b1, OFS_AUX_SEL, 32'h0207);
        rd(OFS_AUX_SEL, "rsp_off", 32'h0201, '1);
        bus(1'b1, OFS_CTRL, 32'h12);
        // Every source on output one, a neighbour on output two
        for (i = 0; i < 8; i++) begin
            bus(1'b1, OFS_AUX_SEL, {20'h0, 4'((i + 1) % 7), 4'h0, 4'(i)});
            @(posedge clk_sys) fn <= 8'($random(seed));
            settle;
            check("lamp1", aux_lamp_one, fn[i]);
            check("lamp2", aux_lamp_two, fn[(i + 1) % 7]);
            check("out1", aux_out_one, fn[i]);
        end
        bus(1'b1, OFS_CTRL, 32'h10);
        @(posedge clk_sys) fn <= 8'h80;
        settle;
        check("rsp_gone", aux_lamp_one, 1'b0);
        // Open in alarm on output one, close in alarm on output two
        bus(1'b1, OFS_AUX_SEL, 32'h0100);
        bus(1'b1, OFS_ALM_POL, 32'h1);
        for (i = 0; i < 4; i++) begin
            @(posedge clk_sys) fn <= {6'h0, i[1:0]};
            settle;
            check("open_out", c1, !fn[0]);
            check("open_lamp", l1, fn[0]);
            check("close_out", c2, fn[1]);
            check("close_lamp", l2, fn[1]);
        end
        // Type codes, alarm three unrouted, an illegal code refused
        bus(1'b1, OFS_ALM_TYPE, 32'h000b0c01);
        rd(OFS_ALM_TYPE, "type_gate", 32'h0201, '1);
        for (i = 1; i < 12; i++) begin
            bus(1'b1, OFS_ALM_TYPE, i);
            rd(OFS_CLASS, "class", {5'h02, cls(i)}, '1);
        end
        // Clamping against ceiling and floor
        bus(1'b1, OFS_SET_POINT, 2000);
        rd(OFS_WORK_SP, "wsp_top", 1300, 32'hffff);
        bus(1'b1, OFS_SP_CEIL, 1301);
        bus(1'b1, OFS_SP_CEIL, 1000);
        ceil = 1000;
        rd(OFS_WORK_SP, "wsp_ceil", 1000, 32'hffff);
        bus(1'b1, OFS_SET_POINT, -500);
        rd(OFS_WORK_SP, "wsp_floor", 16'hff38, 32'hffff);
        bus(1'b1, OFS_SP_FLOOR, 1000);
        rd(OFS_SP_FLOOR, "floor_hi", 16'hff38, 32'hffff);
        // Error term in both senses with random values
        for (i = 0; i < 6; i++) begin
            sp = $random(seed) % 1500;
            pv = $random(seed) % 1500;
            ws = sp > ceil ? ceil : (sp < flr ? flr : sp);
            bus(1'b1, OFS_CTRL, 32'h10 | (i & 1));
            bus(1'b1, OFS_SET_POINT, sp);
            @(posedge clk_sys) process_value <= 16'(pv);
            settle;
            check("ctl_err", control_error,
                {16'h0, 16'((i & 1) ? pv - ws : ws - pv)});
        end
        // Input type changes reload the limits
        bus(1'b1, OFS_SCALE_HI, 500);
        bus(1'b1, OFS_DECIMAL, 2);
        bus(1'b1, OFS_IN_TYPE, 17);
        rd(OFS_SP_CEIL, "ceil_ana", 500, 32'hffff);
        rd(OFS_SP_FLOOR, "floor_ana", 0, 32'hffff);
        rd(OFS_STATUS, "dp_ana", 32'h20000, 32'h30000);
        bus(1'b1, OFS_IN_TYPE, 0);
        rd(OFS_SP_CEIL, "ceil_t0", 6500, 32'hffff);
        rd(OFS_SP_FLOOR, "floor_t0", 16'hf831, 32'hffff);
        rd(OFS_STATUS, "dp_t0", 32'h10000, 32'h30000);
        bus(1'b1, OFS_IN_TYPE, 2);
        rd(OFS_SP_CEIL, "ceil_tmp", 1300, 32'hffff);
        rd(OFS_SP_FLOOR, "floor_tmp", 16'hff38, 32'hffff);
        rd(OFS_STATUS, "dp", 0, 32'h30000);
        // Register access stands in for the two one-second key holds
        // Security above one locks the limits
        bus(1'b1, OFS_CTRL, 32'h20);
        rd(OFS_SP_CEIL, "locked", 0, '1);
        bus(1'b1, OFS_SP_CEIL, 500);
        bus(1'b1, OFS_CTRL, 32'h10);
        rd(OFS_SP_CEIL, "unlocked", 1300, 32'hffff);
        final_report;
    end
endmodule
